/* inc/umsf_pkg.sv */
// umsf_pkg: constants and carrier types for the measurement stream framer
// How it works
// - 32-bit block sequence number at header byte 0, plus one per block sent.
// - fragment kind at header byte 4: 0 whole, 1 opening, 2 following.
// - opening fragment carries datagram count of the block at header byte 6.
// - following fragment carries its position within the block at header byte 6.
// - measured-value messages always go out as one whole frame.
// - each datagram is the fixed header then a content dependent body.
// - body layout chosen by payload kind byte at body start.
// - one profile may be spread across several frames of one block.
// - send to configured destination with only the selected content.
// - profile point count at body byte 20, point i at 24+4*i and +2.
package umsf_pkg;
    localparam int          HDR_BYTES       = 8;
    localparam int          HDR_SEQ_OFS     = 0;
    localparam int          HDR_KIND_OFS    = 4;
    localparam int          HDR_RSVD_OFS    = 5;
    localparam int          HDR_TOTPOS_OFS  = 6;
    localparam int          BODY_CNT_OFS    = 20;
    localparam int          BODY_PTS_OFS    = 24;
    localparam int          PT_BYTES        = 4;
    localparam int          MEAS_BODY_BYTES = 50;
    localparam int          MAX_PTS_PER_FRG = 256;
    localparam logic [31:0] SEQ_RESET       = 32'h0;
    localparam logic [7:0]  RSVD_VALUE      = 8'h00;

    typedef enum logic [7:0] {
        WHOLE_PACKET       = 8'h00,
        OPENING_FRAGMENT   = 8'h01,
        FOLLOWING_FRAGMENT = 8'h02
    } umsf_kind_t;

    typedef enum logic [7:0] {
        PK_MEASURED = 8'h00,
        PK_ZPROF    = 8'h01,
        PK_IPROF    = 8'h02,
        PK_ZIPROF   = 8'h03
    } umsf_payload_t;

    // one byte of the outgoing datagram stream
    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } umsf_beat_t;

    // destination selected by configuration
    typedef struct packed {
        logic [31:0] ip;
        logic [15:0] port;
    } umsf_dest_t;
endpackage : umsf_pkg

/* core/umsf_skid.sv */
// umsf_skid: two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module umsf_skid
    import umsf_pkg::*;
(
    input  wire logic       clk,      // 125 MHz clock
    input  wire logic       resetn,   // async reset, active low
    input  wire umsf_beat_t inData,   // beat from framer
    input  wire logic       inValid,  // framer offers a beat
    output logic            inReady,  // room for a beat
    output umsf_beat_t      outData,  // beat to receiver side
    output logic            outValid, // head entry valid
    input  wire logic       outReady  // receiver takes head
);
    umsf_beat_t spare;      // beat that arrived while the head stalled
    logic       spareValid; // spare entry holds a beat
    logic       headFree;   // head register may be refilled
    logic       push;       // beat taken from the framer

    // the spare entry is what lets a receiver stall lose nothing
    assign inReady  = !spareValid;
    assign headFree = !outValid || outReady;
    assign push     = inValid && inReady;

    // beat storage; head refills from the spare first to keep byte order
    always_ff @(posedge clk) begin
        if (headFree) begin
            if (spareValid) begin
                outData <= spare;
            end else if (inValid) begin
                outData <= inData;
            end
        end else if (push) begin
            spare <= inData;
        end
    end

    // occupancy of head and spare; outputs come straight from these flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outValid   <= 1'b0;
            spareValid <= 1'b0;
        end else if (headFree) begin
            outValid   <= spareValid || inValid;
            spareValid <= 1'b0;
        end else if (push) begin
            spareValid <= 1'b1;
        end
    end
endmodule : umsf_skid

/* core/umsf_framer.sv */
// umsf_framer: builds header and body bytes of streamed datagrams
`timescale 1ns/1ps
module umsf_framer
    import umsf_pkg::*;
(
    input  wire logic          clk,          // 125 MHz clock
    input  wire logic          resetn,       // async reset, active low
    input  wire umsf_dest_t    cfgDest,      // configured destination
    input  wire logic          cfgMeasEn,    // measured values selected
    input  wire logic          cfgProfEn,    // profile data selected
    input  wire logic          reqValid,     // message request
    output logic               reqReady,     // framer idle, request taken
    input  wire umsf_payload_t reqKind,      // payload kind of message
    input  wire logic [15:0]   reqPoints,    // profile point count
    input  wire logic [399:0]  reqMeas,      // measured body bytes 1..49, byte 1 low
    input  wire logic [151:0]  reqProfHdr,   // profile body bytes 1..19, byte 1 low
    output logic [15:0]        ptIndex,      // point being fetched
    input  wire logic [31:0]   ptData,       // x low half, second value high half
    output umsf_beat_t         txData,       // datagram byte
    output logic               txValid,      // byte valid
    input  wire logic          txReady,      // receiver takes byte
    output umsf_dest_t         txDest,       // destination of current datagram
    output logic               dropped       // pulse: request filtered out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_BODY = 2'b11
    } umsf_state_t;

    umsf_state_t state;
    logic [31:0] seqNum;
    umsf_kind_t  fragKind;
    logic [15:0] fragTotal;
    logic [15:0] fragPos;
    logic [15:0] byteIdx;
    logic [15:0] bodyLen;
    logic [15:0] ptsLeft;
    logic [15:0] ptBase;
    umsf_payload_t   curKind;
    logic [399:0] curMeas;
    logic [151:0] curProfHdr;
    logic [7:0]  next_byte;
    umsf_beat_t  bufIn;
    logic        bufValid;
    logic        bufReady;
    logic        beatGo;
    logic        accept;
    logic        isProf;
    logic [15:0] ptsThis;
    logic [15:0] bodyIdx;
    logic [15:0] ptOfs;

    assign isProf   = (reqKind != PK_MEASURED);
    // a request is taken only when idle; unselected content is dropped
    assign accept   = reqValid && (state == ST_IDLE);
    assign beatGo   = bufValid && bufReady;
    assign ptsThis  = (ptsLeft > 16'(MAX_PTS_PER_FRG)) ? 16'(MAX_PTS_PER_FRG) : ptsLeft;
    assign bodyIdx  = byteIdx - 16'(HDR_BYTES);
    assign ptOfs    = bodyIdx - 16'(BODY_PTS_OFS);
    assign bufValid = (state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // header then body byte selection
    always_comb begin
        next_byte = 8'h00;
        if (byteIdx < 16'(HDR_BYTES)) begin
            unique case (byteIdx[2:0])
                3'(HDR_SEQ_OFS):      next_byte = seqNum[7:0];
                3'(HDR_SEQ_OFS + 1):  next_byte = seqNum[15:8];
                3'(HDR_SEQ_OFS + 2):  next_byte = seqNum[23:16];
                3'(HDR_SEQ_OFS + 3):  next_byte = seqNum[31:24];
                3'(HDR_KIND_OFS):     next_byte = fragKind;
                3'(HDR_RSVD_OFS):     next_byte = RSVD_VALUE;
                3'(HDR_TOTPOS_OFS):   next_byte = (fragKind == OPENING_FRAGMENT) ? fragTotal[7:0] : fragPos[7:0];
                3'(HDR_TOTPOS_OFS + 1): next_byte = (fragKind == OPENING_FRAGMENT) ? fragTotal[15:8] : fragPos[15:8];
            endcase
        end else if (bodyIdx == 16'h0) begin
            next_byte = curKind;
        end else if (curKind == PK_MEASURED) begin
            next_byte = curMeas[8*(bodyIdx-16'h1) +: 8];
        end else if (bodyIdx < 16'(BODY_CNT_OFS)) begin
            next_byte = curProfHdr[8*(bodyIdx-16'h1) +: 8];
        end else if (bodyIdx < 16'(BODY_PTS_OFS)) begin
            next_byte = (bodyIdx == 16'(BODY_CNT_OFS))      ? ptsThis[7:0] :
                        (bodyIdx == 16'(BODY_CNT_OFS) + 16'h1) ? ptsThis[15:8] : 8'h00;
        end else begin
            next_byte = ptData[8*ptOfs[1:0] +: 8];
        end
    end

    // point fetch address follows the byte walk, x at 24+4*i
    assign ptIndex = ptBase + (ptOfs >> 2);

    assign bufIn.data  = next_byte;
    assign bufIn.first = (byteIdx == 16'h0);
    assign bufIn.last  = (byteIdx == bodyLen - 16'h1);

    ////////////////////////////////////////////////////////////////////////////
    // datagram walk; measured values never fragment
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= ST_IDLE;
            byteIdx   <= 16'h0;
            bodyLen   <= 16'h0;
            fragKind  <= WHOLE_PACKET;
            fragTotal <= 16'h0;
            fragPos   <= 16'h0;
            ptsLeft   <= 16'h0;
            ptBase    <= 16'h0;
            seqNum    <= SEQ_RESET;
            dropped   <= 1'b0;
            reqReady  <= 1'b1;
        end else begin
            dropped <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        if (isProf ? !cfgProfEn : !cfgMeasEn) begin
                            dropped <= 1'b1;
                        end else if (!isProf || reqPoints <= 16'(MAX_PTS_PER_FRG)) begin
                            fragKind  <= WHOLE_PACKET;
                            fragTotal <= 16'h1;
                            reqReady  <= 1'b0;
                            state     <= ST_HDR;
                        end else begin
                            fragKind  <= OPENING_FRAGMENT;
                            fragTotal <= 16'((32'(reqPoints) + MAX_PTS_PER_FRG - 1) / MAX_PTS_PER_FRG);
                            reqReady  <= 1'b0;
                            state     <= ST_HDR;
                        end
                        fragPos <= 16'h0;
                        byteIdx <= 16'h0;
                        ptsLeft <= reqPoints;
                        ptBase  <= 16'h0;
                        bodyLen <= isProf ? 16'(HDR_BYTES + BODY_PTS_OFS) +
                                   16'(PT_BYTES) * ((reqPoints > 16'(MAX_PTS_PER_FRG)) ?
                                   16'(MAX_PTS_PER_FRG) : reqPoints) : 16'(HDR_BYTES + MEAS_BODY_BYTES);
                    end
                end
                ST_HDR, ST_BODY: begin
                    if (beatGo) begin
                        byteIdx <= byteIdx + 16'h1;
                        state   <= ST_BODY;
                        if (bufIn.last) begin
                            byteIdx <= 16'h0;
                            if (curKind != PK_MEASURED && ptsLeft > ptsThis) begin
                                // next fragment of the same block
                                fragKind <= FOLLOWING_FRAGMENT;
                                fragPos  <= fragPos + 16'h1;
                                ptsLeft  <= ptsLeft - ptsThis;
                                ptBase   <= ptBase + ptsThis;
                                bodyLen  <= 16'(HDR_BYTES + BODY_PTS_OFS) + 16'(PT_BYTES) *
                                            ((ptsLeft - ptsThis > 16'(MAX_PTS_PER_FRG)) ?
                                            16'(MAX_PTS_PER_FRG) : ptsLeft - ptsThis);
                                state    <= ST_HDR;
                            end else begin
                                seqNum <= seqNum + 32'h1;
                                reqReady <= 1'b1; // idle again once the block is buffered
                                state  <= ST_IDLE;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // message capture at acceptance
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            curKind    <= PK_MEASURED;
            curMeas    <= '0;
            curProfHdr <= '0;
            txDest     <= '0;
        end else if (accept) begin
            curKind    <= reqKind;
            curMeas    <= reqMeas;
            curProfHdr <= reqProfHdr;
            txDest     <= cfgDest;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output buffer so a receiver stall loses no byte
    umsf_skid u_skid (
        .clk      (clk),
        .resetn   (resetn),
        .inData   (bufIn),
        .inValid  (bufValid),
        .inReady  (bufReady),
        .outData  (txData),
        .outValid (txValid),
        .outReady (txReady)
    );
endmodule : umsf_framer

/* tb/umsf_checker.sv */
// umsf_checker: port-level assertions for the stream framer
`timescale 1ns/1ps
module umsf_checker
    import umsf_pkg::*;
(
    input wire logic          clk,       // clock
    input wire logic          resetn,    // async reset, active low
    input wire umsf_dest_t    cfgDest,   // configured destination
    input wire logic          cfgMeasEn, // measured enable
    input wire logic          cfgProfEn, // profile enable
    input wire logic          reqValid,  // request
    input wire logic          reqReady,  // framer idle
    input wire umsf_payload_t reqKind,   // payload kind
    input wire umsf_beat_t    txData,    // outgoing beat
    input wire logic          txValid,   // beat valid
    input wire logic          txReady,   // beat taken
    input wire umsf_dest_t    txDest,    // current destination
    input wire logic          dropped    // filter pulse
);
    logic [15:0] pos;
    logic [7:0]  kindSeen;
    wire logic   sel = (reqKind == PK_MEASURED) ? cfgMeasEn : cfgProfEn;

    ////////////////////////////////////////////////////////////////////////
    // byte position within the datagram, and the fragment kind it carried
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pos <= 16'h0;
            kindSeen <= 8'h00;
        end else if (txValid && txReady) begin
            pos <= txData.last ? 16'h0 : pos + 16'h1;
            if (pos == 16'h0004) kindSeen <= txData.data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        reqValid && reqReady;
    endsequence
    sequence s_pass;
        s_take ##0 sel;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // buffer may still drain the previous block, hence a short window
    take_answer_a: assert property (s_pass |=> ##[0:8] (txValid && txData.first))
        else $error("no datagram after accepted request");
    busy_block_a: assert property (s_pass |=> !reqReady)
        else $error("framer idle right after request");
    drop_pulse_a: assert property (s_take ##0 !sel |=> dropped ##1 !dropped)
        else $error("filtered request without single pulse");
    dest_latch_a: assert property (s_pass |=> txDest == $past(cfgDest))
        else $error("destination not taken at request");
    beat_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("beat changed while stalled");
    first_pos_a: assert property (txValid && txData.first |-> pos == 16'h0)
        else $error("first flag off header start");
    kind_code_a: assert property (txValid && pos == 16'h0004 |-> txData.data <= 8'h02)
        else $error("bad fragment kind code");
    rsvd_byte_a: assert property (txValid && pos == 16'h0005 |-> txData.data == RSVD_VALUE)
        else $error("reserved header byte not zero");
    meas_whole_a: assert property (txValid && pos == 16'h0008 && txData.data == 8'h00 |-> kindSeen == 8'h00)
        else $error("measured message fragmented");
endmodule : umsf_checker

bind umsf_framer umsf_checker chk (.clk(clk), .resetn(resetn), .cfgDest(cfgDest), .cfgMeasEn(cfgMeasEn),
    .cfgProfEn(cfgProfEn), .reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind), .txData(txData),
    .txValid(txValid), .txReady(txReady), .txDest(txDest), .dropped(dropped));

/* tb/umsf_rx_model.sv */
// umsf_rx_model: network receiver that collects datagram bytes
`timescale 1ns/1ps
module umsf_rx_model
    import umsf_pkg::*;
(
    input  wire logic       clk,     // clock
    input  wire logic       resetn,  // async reset, active low
    input  wire umsf_beat_t txData,  // datagram byte
    input  wire logic       txValid, // byte offered
    output logic            txReady, // byte taken
    input  wire logic       slow     // stall two cycles of four
);
    logic [7:0] mem [0:4095];
    logic [1:0] fl  [0:4095];
    int         cnt;
    logic [1:0] tog;

    // stall pattern, registered so ready moves just after an edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) tog <= 2'h0;
        else tog <= tog + 2'h1;
    end
    assign txReady = !slow || tog[1];

    // bytes kept in arrival order, so fragment bodies join by position
    always @(posedge clk) begin
        if (txValid && txReady) begin
            mem[cnt] <= txData.data;
            fl[cnt] <= {txData.first, txData.last};
            cnt <= cnt + 1;
        end
    end
endmodule : umsf_rx_model

/* tb/udp_measurement_stream_framer_tb_top.sv */
// udp_measurement_stream_framer_tb_top: scenario testbench for the framer
`timescale 1ns/1ps
module udp_measurement_stream_framer_tb_top
    import umsf_pkg::*;
;
    logic          clk, resetn, cfgMeasEn, cfgProfEn, reqValid, reqReady, txValid, txReady, dropped, slow;
    umsf_dest_t    cfgDest, txDest;
    umsf_payload_t reqKind;
    logic [15:0]   reqPoints, ptIndex;
    logic [399:0]  reqMeas;
    logic [151:0]  reqProfHdr;
    logic [31:0]   ptData;
    umsf_beat_t    txData;
    int            errors, checked, base;

    function automatic logic [31:0] pt(input logic [15:0] i);
        return {i ^ 16'h5a5a, i};
    endfunction : pt
    assign ptData = pt(ptIndex); // same-cycle point reply

    umsf_framer DUT (.clk(clk), .resetn(resetn), .cfgDest(cfgDest), .cfgMeasEn(cfgMeasEn), .cfgProfEn(cfgProfEn),
        .reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind), .reqPoints(reqPoints), .reqMeas(reqMeas),
        .reqProfHdr(reqProfHdr), .ptIndex(ptIndex), .ptData(ptData), .txData(txData), .txValid(txValid),
        .txReady(txReady), .txDest(txDest), .dropped(dropped));
    umsf_rx_model rx (.clk(clk), .resetn(resetn), .txData(txData), .txValid(txValid), .txReady(txReady), .slow(slow));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rd(input int a, input int n);
        logic [31:0] v;
        v = 32'h0;
        for (int i = n - 1; i >= 0; i--) v = {v[23:0], rx.mem[a + i]};
        return v;
    endfunction : rd

    task check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // request held until taken, then wait for the whole block at the receiver
    task send(input umsf_payload_t k, input logic [15:0] n, input int len);
        int i;
        base = rx.cnt;
        reqKind <= k;
        reqPoints <= n;
        reqValid <= 1'b1;
        for (i = 0; i < 100 && reqReady !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        reqValid <= 1'b0;
        for (i = 0; i < 6000 && rx.cnt < base + len; i++) @(posedge clk);
        check(rx.cnt - base, len);
    endtask : send

    task t_meas;
        send(PK_MEASURED, 16'h0, 58);
        check(rd(base, 4), 32'h0);
        check(rd(base + 4, 1), 32'h0);
        check(rd(base + 5, 3), 32'h0);
        check(rd(base + 8, 1), 32'h0);
        check(rd(base + 9, 1), 32'h31);
        check(rx.fl[base + 57], 2'h1);
        check(txDest, cfgDest);
        $display("test meas done");
    endtask : t_meas

    // 300 points split as 256 + 44 while the receiver stalls
    task t_prof;
        slow <= 1'b1;
        send(PK_ZPROF, 16'd300, 1264);
        check(rd(base, 4), 32'h1);
        check(rd(base + 1056, 4), 32'h1);
        check(rd(base + 4, 1), 32'h1);
        check(rd(base + 6, 2), 32'h2);
        check(rd(base + 1060, 1), 32'h2);
        check(rd(base + 1062, 2), 32'h1);
        check(rx.fl[base + 1056], 2'h2);
        check(rd(base + 9, 1), 32'h41);
        check(rd(base + 28, 4), 32'd256);
        check(rd(base + 1084, 4), 32'd44);
        check(rd(base + 32, 4), pt(16'd0));
        check(rd(base + 1052, 4), pt(16'd255));
        check(rd(base + 1088, 4), pt(16'd256));
        check(rd(base + 1260, 4), pt(16'd299));
        slow <= 1'b0;
        $display("test prof done");
    endtask : t_prof

    task t_kinds;
        for (int k = 2; k < 4; k++) begin
            send(umsf_payload_t'(k), 16'd2, 40);
            check(rd(base, 4), k);
            check(rd(base + 4, 1), 32'h0);
            check(rd(base + 8, 1), k);
            check(rd(base + 36, 4), pt(16'd1));
        end
        $display("test kinds done");
    endtask : t_kinds

    // first pass filters measured values, second pass filters profiles
    task t_drop;
        for (int k = 0; k < 2; k++) begin
            {cfgMeasEn, cfgProfEn} <= k ? 2'h2 : 2'h1;
            send(k ? PK_IPROF : PK_MEASURED, 16'd2, 0);
            @(negedge clk);
            check(dropped, 1'b1);
            repeat (4) @(posedge clk);
            check(rx.cnt - base, 0);
        end
        {cfgMeasEn, cfgProfEn} <= 2'h3;
        $display("test drop done");
    endtask : t_drop

    // drops leave the sequence alone; a mid-run reset brings it back to zero
    task t_reset;
        send(PK_MEASURED, 16'h0, 58);
        check(rd(base, 4), 32'h4);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check(txValid, 1'b0);
        check(reqReady, 1'b1);
        resetn <= 1'b1;
        send(PK_MEASURED, 16'h0, 58);
        check(rd(base, 4), 32'h0);
        $display("test reset done");
    endtask : t_reset

    task stop_test;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // watchdog: whole run needs well under a fifth of this span
    initial begin
        #(8 * 40000);
        errors++;
        stop_test();
    end

    initial begin
        {resetn, reqValid, slow, reqKind, reqPoints} = '0;
        {cfgMeasEn, cfgProfEn} = 2'h3;
        cfgDest = {32'h0a000002, 16'h1f90};
        for (int k = 1; k < 50; k++) reqMeas[8 * (k - 1) +: 8] = 8'h30 + k[7:0];
        for (int k = 1; k < 20; k++) reqProfHdr[8 * (k - 1) +: 8] = 8'h40 + k[7:0];
        reqMeas[399:392] = 8'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_meas();
        t_prof();
        t_kinds();
        t_drop();
        t_reset();
        stop_test();
    end
endmodule : udp_measurement_stream_framer_tb_top
